// ===== hw/user_cfg_pkg.sv
package user_cfg_pkg;
	localparam logic [7:0]  CMD_USER_FEATURE_CONFIG = 8'hd1;
	localparam logic [15:0] USER_CFG_RESET          = 16'h0402;
	localparam int          MIN_DUTY_MSB            = 15;
	localparam int          MIN_DUTY_LSB            = 11;
	localparam int          DRIVE_MODE_BIT          = 10;
	localparam int          MIN_DUTY_EN_BIT         = 7;
	localparam int          PERIOD_BITS             = 9;
	localparam logic [8:0]  PERIOD_LAST             = 9'h1ff;
	// one byte of the frame while it is assembled
	typedef enum logic [0:0] {
		BYTE_LOW  = 1'b0,
		BYTE_HIGH = 1'b1
	} byte_sel_t;
endpackage

// ===== hw/user_feature_config_reg.sv
`timescale 1ns/1ps
module user_feature_config_reg #(
	parameter int PAGES = 2
) (
	// clock and reset
	input  wire logic                  MCLK_I,
	input  wire logic                  RESET_I,
	// command port from the management bus engine
	input  wire logic [7:0]            CMD_I,
	input  wire logic [$clog2(PAGES)-1:0] PAGE_I,
	input  wire logic                  WR_BYTE_I,
	input  wire logic [7:0]            WR_DATA_I,
	input  wire logic                  WR_PROTECT_I,
	input  wire logic                  RD_BYTE_I,
	output logic      [7:0]            RD_DATA_O,
	output logic                       WR_REJECT_O,
	// modulator side, one demand per output
	input  wire logic [PAGES*9-1:0]    DUTY_DEMAND_I,
	output logic      [PAGES-1:0]      LOW_SIDE_DRIVE_OUT_O,
	output logic      [PAGES-1:0]      HIGH_SIDE_DRIVE_OUT_O
);
	import user_cfg_pkg::*;

	logic [15:0]          cfg_reg [PAGES];
	logic [15:0]          cfg_next [PAGES];
	logic [15:0]          act_reg [PAGES];
	logic [15:0]          act_next [PAGES];
	logic [7:0]           low_reg, low_next;
	byte_sel_t            wsel_reg, wsel_next;
	byte_sel_t            rsel_reg, rsel_next;
	logic [7:0]           rd_reg, rd_next;
	logic                 rej_reg, rej_next;
	logic [PERIOD_BITS-1:0] cnt_reg, cnt_next;
	logic [PAGES-1:0]     lo_reg, lo_next, hi_reg, hi_next;
	logic                 hit;

	// command decode; any other command code parks both byte pointers,
	// so a frame cut by a new command never leaves a half word behind
	assign hit = (CMD_I == CMD_USER_FEATURE_CONFIG);

	// byte assembly, low byte first; the word commits on its high byte
	// so a torn write never reaches the modulator
	always_comb begin
		cfg_next  = cfg_reg;
		low_next  = low_reg;
		wsel_next = wsel_reg;
		rsel_next = rsel_reg;
		rd_next   = rd_reg;
		rej_next  = 1'b0;
		if (!hit) begin
			wsel_next = BYTE_LOW;
			rsel_next = BYTE_LOW;
		end
		if (hit && WR_BYTE_I) begin
			if (WR_PROTECT_I) begin
				rej_next  = 1'b1;
				wsel_next = BYTE_LOW;
			end else if (wsel_reg == BYTE_LOW) begin
				low_next  = WR_DATA_I;
				wsel_next = BYTE_HIGH;
			end else begin
				cfg_next[PAGE_I] = {WR_DATA_I, low_reg};
				wsel_next = BYTE_LOW;
			end
		end
		if (hit && RD_BYTE_I) begin
			// reads ignore protection
			rd_next   = (rsel_reg == BYTE_LOW) ? cfg_reg[PAGE_I][7:0]
						: cfg_reg[PAGE_I][15:8];
			rsel_next = (rsel_reg == BYTE_LOW) ? BYTE_HIGH : BYTE_LOW;
		end
	end

	// switching period counter; 200 MHz over 512 counts is the frame
	// the active copy is only reloaded on the last count, so a host
	// write in mid-period never cuts the pulse already under way
	always_comb begin
		cnt_next = cnt_reg + 9'h001;
		act_next = act_reg;
		if (cnt_reg == PERIOD_LAST)
			act_next = cfg_reg;
	end

	// modulator: compare against demand, with optional duty floor
	// limitation: the floor only raises short pulses, it never clips
	// a demand that is already above it
	always_comb begin
		logic [9:0] floor_cnt;
		logic [8:0] duty;
		floor_cnt = 10'h000;
		duty      = 9'h000;
		lo_next   = '0;
		hi_next   = '0;
		for (int p = 0; p < PAGES; p++) begin
			duty = DUTY_DEMAND_I[p*9 +: 9];
			// 2*(v+1)/512 of the period, in counts
			floor_cnt = {4'h0, act_reg[p][MIN_DUTY_MSB:MIN_DUTY_LSB], 1'b0}
				+ 10'h002;
			if (act_reg[p][MIN_DUTY_EN_BIT] &&
				{1'b0, duty} < floor_cnt)
				duty = floor_cnt[8:0];
			if (act_reg[p][DRIVE_MODE_BIT]) begin
				lo_next[p] = 1'b1;
				hi_next[p] = (cnt_reg < duty);
			end else begin
				hi_next[p] = (cnt_reg < duty);
				lo_next[p] = !(cnt_reg < duty);
			end
		end
	end

	// registers; every copy resets to its default
	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			for (int p = 0; p < PAGES; p++) begin
				cfg_reg[p] <= USER_CFG_RESET;
				act_reg[p] <= USER_CFG_RESET;
			end
			low_reg  <= 8'h00;
			wsel_reg <= BYTE_LOW;
			rsel_reg <= BYTE_LOW;
			rd_reg   <= 8'h00;
			rej_reg  <= 1'b0;
			cnt_reg  <= 9'h000;
			lo_reg   <= '0;
			hi_reg   <= '0;
		end else begin
			cfg_reg  <= cfg_next;
			act_reg  <= act_next;
			low_reg  <= low_next;
			wsel_reg <= wsel_next;
			rsel_reg <= rsel_next;
			rd_reg   <= rd_next;
			rej_reg  <= rej_next;
			cnt_reg  <= cnt_next;
			lo_reg   <= lo_next;
			hi_reg   <= hi_next;
		end
	end

	assign RD_DATA_O             = rd_reg;
	assign WR_REJECT_O           = rej_reg;
	assign LOW_SIDE_DRIVE_OUT_O  = lo_reg;
	assign HIGH_SIDE_DRIVE_OUT_O = hi_reg;
endmodule

// ===== verification/cfg_props.sv
`timescale 1ns/1ps
module cfg_props
	import user_cfg_pkg::*;
#(parameter int PAGES = 2) (
	input wire logic             MCLK_I, RESET_I, WR_BYTE_I, WR_PROTECT_I,
	input wire logic             RD_BYTE_I, WR_REJECT_O,
	input wire logic [7:0]       CMD_I, RD_DATA_O,
	input wire logic [PAGES-1:0] LOW_SIDE_DRIVE_OUT_O, HIGH_SIDE_DRIVE_OUT_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RESET_I);
	// a data byte aimed at this register
	sequence wr_sel; CMD_I == CMD_USER_FEATURE_CONFIG && WR_BYTE_I; endsequence
	rej_pulse_a: assert property (wr_sel ##0 WR_PROTECT_I |=> WR_REJECT_O)
		else $error("protected write not refused");
	rej_free_a: assert property (wr_sel ##0 !WR_PROTECT_I |=> !WR_REJECT_O)
		else $error("open write refused");
	rej_cause_a: assert property (WR_REJECT_O |->
		$past(CMD_I == CMD_USER_FEATURE_CONFIG && WR_BYTE_I && WR_PROTECT_I))
		else $error("refusal without protection");
	off_cmd_a: assert property (CMD_I != CMD_USER_FEATURE_CONFIG |=> !WR_REJECT_O)
		else $error("refusal on foreign command");
	rd_hold_a: assert property (!RD_BYTE_I |=> $stable(RD_DATA_O))
		else $error("read byte moved without a read");
	// in either mode one of the two drives is high every cycle
	drive_live_a: assert property (!$past(RESET_I) |->
		&(LOW_SIDE_DRIVE_OUT_O | HIGH_SIDE_DRIVE_OUT_O)) else $error("both low");
	low_fall0_a: assert property ($fell(LOW_SIDE_DRIVE_OUT_O[0]) |->
		$rose(HIGH_SIDE_DRIVE_OUT_O[0])) else $error("low fell alone, out 0");
	low_fall1_a: assert property ($fell(LOW_SIDE_DRIVE_OUT_O[1]) |->
		$rose(HIGH_SIDE_DRIVE_OUT_O[1])) else $error("low fell alone, out 1");
endmodule
bind user_feature_config_reg cfg_props #(.PAGES(PAGES)) u_props (.*);

// ===== verification/mgmt_host.sv
`timescale 1ns/1ps
module mgmt_host
	import user_cfg_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic [7:0] rd_data_i,
	output logic      [7:0] cmd_o, data_o,
	output logic            page_o, wr_o, rd_o, prot_o
);
	localparam logic [7:0] STORE_CMD = 8'h15; // arbitrary store code
	initial {cmd_o, data_o, page_o, wr_o, rd_o, prot_o} = '0;
	// low byte first; idle data is inverted so it never looks valid
	task automatic wr(input logic p, pr, input logic [15:0] w);
		@(posedge clk_i) {cmd_o, page_o, prot_o, wr_o} <=
			{CMD_USER_FEATURE_CONFIG, p, pr, 1'b1};
		data_o <= w[7:0];
		@(posedge clk_i) data_o <= w[15:8];
		@(posedge clk_i) {wr_o, data_o} <= {1'b0, ~w[15:8]};
		cmd_o <= STORE_CMD;
	endtask
	// read byte is sampled before the edge updates it
	task automatic rd(input logic p, output logic [15:0] w);
		@(posedge clk_i) {cmd_o, page_o, rd_o} <=
			{CMD_USER_FEATURE_CONFIG, p, 1'b1};
		@(posedge clk_i);
		@(posedge clk_i) w[7:0] = rd_data_i;
		rd_o <= 1'b0;
		@(posedge clk_i) w[15:8] = rd_data_i;
	endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
	import user_cfg_pkg::*;
	logic clk = 0, rst = 1, wr, rd, prot, page, rej;
	logic [7:0] cmd, data, rdd;
	logic [17:0] demand = '0;
	logic [1:0] low, high;
	logic [15:0] v;
	int num_errors = 0, checks_done = 0, cyc = 0, hc[2], lc[2];
	always #2.5 clk = ~clk;
	user_feature_config_reg u_dut (.MCLK_I(clk), .RESET_I(rst), .CMD_I(cmd),
		.PAGE_I(page), .WR_BYTE_I(wr), .WR_DATA_I(data), .WR_PROTECT_I(prot),
		.RD_BYTE_I(rd), .RD_DATA_O(rdd), .WR_REJECT_O(rej),
		.DUTY_DEMAND_I(demand), .LOW_SIDE_DRIVE_OUT_O(low),
		.HIGH_SIDE_DRIVE_OUT_O(high));
	mgmt_host u_host (.clk_i(clk), .rd_data_i(rdd), .cmd_o(cmd),
		.data_o(data), .page_o(page), .wr_o(wr), .rd_o(rd), .prot_o(prot));
	task chk(input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %h vs %h", $time, seen, exp);
		end
	endtask
	task rdchk(input logic p, input logic [15:0] exp);
		u_host.rd(p, v);
		chk(v, exp);
	endtask
	// settle past two boundaries, then one window of 512 is one period
	task duty;
		hc = '{0, 0};
		lc = '{0, 0};
		repeat (1024) @(posedge clk);
		for (int i = 0; i < 512; i++) begin
			@(posedge clk);
			foreach (hc[p]) begin hc[p] += high[p]; lc[p] += low[p]; end
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) if (++cyc == 10000) begin num_errors++; test_done; end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rdchk(0, USER_CFG_RESET);
		rdchk(1, USER_CFG_RESET);
		u_host.wr(0, 0, 16'ha5c3);
		u_host.wr(1, 0, 16'h5a3c);
		rdchk(0, 16'ha5c3);
		rdchk(1, 16'h5a3c);
		u_host.wr(0, 1, 16'h1234);
		rdchk(0, 16'ha5c3);
		$display("test registers done");
		// out 0: floor 2*(3+1) on zero demand; out 1: stage mode
		u_host.wr(0, 0, 16'h1880);
		u_host.wr(1, 0, 16'h0400);
		demand <= {9'd100, 9'd0};
		duty;
		chk(16'(hc[0]), 16'd8);
		chk(16'(lc[0]), 16'd504);
		chk(16'(hc[1]), 16'd100);
		chk(16'(lc[1]), 16'd512);
		u_host.wr(0, 0, 16'h1800);
		duty;
		chk(16'(hc[0]), 16'd0);
		$display("test modulator done");
		test_done;
	end
endmodule
